/* File: lcdc_chk.sv */
// Purpose : Port assertions for the clock and port config block
// Assumes : One clock domain
// Notes   : Bound to the top module
`timescale 1ns/10ps
`default_nettype none
module lcdc_chk (
    // Clock and reset
    input wire logic        sys_clk,
    input wire logic        rstn,
    // Bus
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_we_i,
    input wire logic [3:0]  wb_adr_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic        wb_ack_o,
    // Link and outputs
    input wire logic        chip_select_a,
    input wire logic        pwm_frame_freq,
    input wire logic        pwm_enable,
    input wire logic [3:0]  pin_port_mask,
    input wire logic        port4_out
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rstn);
    // Idle long enough for a pending commit to land
    sequence s_quiet;
        (!chip_select_a && !wb_cyc_i)[*4];
    endsequence
    a_ack_follows: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("no ack");
    a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("long ack");
    a_ack_cause: assert property ($rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i))
        else $error("stray ack");
    a_unmapped_zero: assert property (wb_ack_o && !wb_we_i && wb_adr_i == 4'hc |-> wb_dat_o == 32'h0)
        else $error("unmapped read");
    a_mask_legal: assert property (pin_port_mask inside {4'h0, 4'h1, 4'h3, 4'h7, 4'hf})
        else $error("bad pin map");
    a_quiet_hold: assert property (s_quiet |-> $stable(pin_port_mask))
        else $error("map moved idle");
    a_pwm_off_slow: assert property ((!pwm_enable)[*3] |-> !pwm_frame_freq)
        else $error("pwm in slow mode");
    a_port4_idle: assert property ((!pin_port_mask[3])[*3] |-> !port4_out)
        else $error("pin four driven");
endmodule
bind lcdc_clk_port_cfg lcdc_chk i_lcdc_chk (.sys_clk(sys_clk), .rstn(rstn), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .chip_select_a(chip_select_a), .pwm_frame_freq(pwm_frame_freq),
    .pwm_enable(pwm_enable), .pin_port_mask(pin_port_mask), .port4_out(port4_out));
`default_nettype wire

/* File: lcdc_clk_port_cfg.sv */
// Purpose : Base clock select, frame dividers, shared pin mapping and serial config gating
// Assumes : Serial and external clock pins are synchronous to sys_clk
// Notes   : Notes on behaviour below
//
// Notes on behaviour
// (R1) 300 kHz mode: pulse-width frame divisor is 1536 minus 128 times code, codes 0-10.
// (R2) 300 kHz mode: pulse-width frame codes 11-15 use divisor 896.
// (R3) Source bit 0 picks internal oscillator; else rate bit picks 300 kHz or 38 kHz.
// (R4) 38 kHz mode has no pulse-width function; ports give static levels only.
// (R5) 38 kHz mode: display frame divisor from MSB-first code, 768 down to 96.
// (R6) Three-bit pin map assigns four shared pins as segment or port outputs.
// (R7) Controller writes zero to unused function, duty and frame select bits.
// (R8) Fourth port with both function bits zero is a plain output.
// (R9) Plain fourth port output mirrors display data bit ten.
// (R10) 38 kHz mode: indicator ports are only fully on or off.
// (R11) Chip enable low: serial clock and data ignored, state unchanged.
// (R12) Controller shares clock and data but gives each device its own enable.
// (R13) Controller holds other devices' enables low during a transfer.
// (R14) Serial settings take effect only after a complete transfer ends.
//
// Decided for this implementation: the placing of the registers and the Wishbone register port.
`timescale 1ns/10ps
`default_nettype none
module lcdc_clk_port_cfg
    import lcdc_pkg::*;
#(
    parameter int unsigned OSC_DIV = INT_OSC_DIV
) (
    // Clock and reset
    input  wire logic        sys_clk,
    input  wire logic        rstn,
    // Wishbone slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [3:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic [31:0]      wb_dat_o,
    output logic             wb_ack_o,
    // Serial control link
    input  wire logic        serial_clk_in,
    input  wire logic        serial_data_in,
    input  wire logic        chip_select_a,
    // External base clock
    input  wire logic        ext_clk_in,
    // Frame and port outputs
    output logic             disp_frame_freq,
    output logic             pwm_frame_freq,
    output logic             pwm_enable,
    output logic [3:0]       pin_port_mask,
    output logic             port4_out
);

    // ------------------------------------------------------------
    // Reset release
    // ------------------------------------------------------------
    logic rst_s1_r;
    logic rst_n_r;

    // Two-stage release keeps deassertion clean
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            rst_s1_r <= 1'b0;
            rst_n_r  <= 1'b0;
        end else begin
            rst_s1_r <= 1'b1;
            rst_n_r  <= rst_s1_r;
        end
    end

    // ------------------------------------------------------------
    // Serial link shadow
    // ------------------------------------------------------------
    logic [CFG_W-1:0] shadow_r;
    logic [4:0]       bit_cnt_r;
    logic             sclk_d_r;
    logic             cs_d_r;
    logic             serial_commit;

    // Edge detect on the serial clock; no update with enable low
    always_ff @(posedge sys_clk or negedge rst_n_r) begin
        if (!rst_n_r) begin
            sclk_d_r <= 1'b0;
            cs_d_r   <= 1'b0;
        end else begin
            sclk_d_r <= serial_clk_in;
            cs_d_r   <= chip_select_a;
        end
    end

    // Shift MSB first while selected; count bits for completeness
    always_ff @(posedge sys_clk or negedge rst_n_r) begin
        if (!rst_n_r) begin
            shadow_r  <= '0;
            bit_cnt_r <= '0;
        end else if (chip_select_a && !cs_d_r) begin
            bit_cnt_r <= '0;                              // New transfer starts
        end else if (chip_select_a && serial_clk_in && !sclk_d_r) begin // R11
            shadow_r  <= {shadow_r[CFG_W-2:0], serial_data_in};
            if (bit_cnt_r != 5'(CFG_W))
                bit_cnt_r <= bit_cnt_r + 5'd1;
        end
    end

    // Commit only when enable falls after a full word; short frames are dropped
    assign serial_commit = cs_d_r && !chip_select_a && (bit_cnt_r == 5'(CFG_W)); // R14

    // ------------------------------------------------------------
    // Control register and Wishbone slave
    // ------------------------------------------------------------
    logic [CFG_W-1:0]  ctrl_r;
    logic              wb_req;
    logic              wb_wr;
    lcdc_clk_mode_type clk_mode;

    // Write lands at the edge where ack is seen high, so a master that holds until ack writes once
    assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign wb_wr  = wb_cyc_i && wb_stb_i && wb_ack_o && wb_we_i && (wb_adr_i == ADDR_CTRL);

    // Active config; serial commit wins over a bus write in the same cycle
    always_ff @(posedge sys_clk or negedge rst_n_r) begin
        if (!rst_n_r) begin
            ctrl_r <= CTRL_RESET;
        end else if (serial_commit) begin
            ctrl_r <= shadow_r;                           // R14
        end else if (wb_wr) begin
            if (wb_sel_i[0])
                ctrl_r[7:0]  <= wb_dat_i[7:0];
            if (wb_sel_i[1])
                ctrl_r[15:8] <= wb_dat_i[15:8];
        end
    end

    // Ack one cycle after request; unmapped addresses read zero
    always_ff @(posedge sys_clk or negedge rst_n_r) begin
        if (!rst_n_r) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= '0;
        end else begin
            wb_ack_o <= wb_req;
            if (wb_req) begin
                unique case (wb_adr_i)
                    ADDR_CTRL:   wb_dat_o <= {16'h0000, ctrl_r};
                    ADDR_STATUS: wb_dat_o <= {22'h000000, clk_mode, 1'b0, pwm_frame_freq,
                                              disp_frame_freq, pwm_enable, pin_port_mask};
                    ADDR_SHADOW: wb_dat_o <= {11'h000, bit_cnt_r, shadow_r};
                    default:     wb_dat_o <= '0;
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // Field decode
    // ------------------------------------------------------------
    logic       clock_source_sel;
    logic       ext_rate_sel;
    logic [3:0] pwm_frame_code;
    logic [3:0] disp_frame_code;
    logic [2:0] pin_map_code;
    logic [1:0] port4_func;
    logic       disp_data_bit10;

    assign clock_source_sel = ctrl_r[F_CLK_SRC];
    assign ext_rate_sel     = ctrl_r[F_EXT_RATE];
    assign pwm_frame_code   = ctrl_r[F_PWM_LSB +: 4];    // b0 is least significant
    assign disp_frame_code  = ctrl_r[F_DISP_LSB +: 4];   // b3 is most significant
    assign pin_map_code     = ctrl_r[F_PMAP_LSB +: 3];   // b0 is most significant
    assign port4_func       = ctrl_r[F_P4F_LSB +: 2];
    assign disp_data_bit10  = ctrl_r[F_D10];

    // ------------------------------------------------------------
    // Base clock selection
    // ------------------------------------------------------------
    logic [9:0]        osc_cnt_r;
    logic              osc_tick_r;
    logic              ext_d_r;
    logic              base_tick;

    // Rate bit is don't-care on the internal oscillator
    always_comb begin
        if (!clock_source_sel)
            clk_mode = LCDC_CLK_INT;                      // R3
        else if (!ext_rate_sel)
            clk_mode = LCDC_CLK_EXT300;                   // R3
        else
            clk_mode = LCDC_CLK_EXT38;                    // R3
    end

    // Internal oscillator stand-in from the system clock
    always_ff @(posedge sys_clk or negedge rst_n_r) begin
        if (!rst_n_r) begin
            osc_cnt_r  <= '0;
            osc_tick_r <= 1'b0;
        end else if (osc_cnt_r == 10'(OSC_DIV - 1)) begin
            osc_cnt_r  <= '0;
            osc_tick_r <= 1'b1;
        end else begin
            osc_cnt_r  <= osc_cnt_r + 10'd1;
            osc_tick_r <= 1'b0;
        end
    end

    // Rising edges of the external clock
    always_ff @(posedge sys_clk or negedge rst_n_r) begin
        if (!rst_n_r)
            ext_d_r <= 1'b0;
        else
            ext_d_r <= ext_clk_in;
    end

    assign base_tick = (clk_mode == LCDC_CLK_INT) ? osc_tick_r : (ext_clk_in && !ext_d_r);

    // ------------------------------------------------------------
    // Divisor selection
    // ------------------------------------------------------------
    logic [DIV_W-1:0] disp_div;
    logic [DIV_W-1:0] pwm_div;

    // Fast modes share the 300 kHz display table, eight times the 38 kHz one
    always_comb begin
        if (clk_mode == LCDC_CLK_EXT38)
            disp_div = DISP_38K_DIV[disp_frame_code];     // R5
        else
            disp_div = DIV_W'(DISP_38K_DIV[disp_frame_code] * DISP_300K_MUL);
    end

    // Linear steps up to code 10, fixed above
    always_comb begin
        if (pwm_frame_code <= PWM_CODE_MAX)
            pwm_div = PWM_DIV_BASE - DIV_W'(PWM_DIV_STEP * pwm_frame_code); // R1
        else
            pwm_div = PWM_DIV_FIXED;                      // R2
    end

    // No pulse-width engine on the slow external clock
    assign pwm_enable = (clk_mode != LCDC_CLK_EXT38);     // R4 R10

    // ------------------------------------------------------------
    // Frame dividers
    // ------------------------------------------------------------
    lcdc_frame_div #(
        .W           (DIV_W)
    ) u_disp_div (
        .clk         (sys_clk),
        .rst_n       (rst_n_r),
        .en          (1'b1),
        .tick        (base_tick),
        .divisor     (disp_div),
        .frame_pulse (),
        .frame_tgl   (disp_frame_freq)
    );

    lcdc_frame_div #(
        .W           (DIV_W)
    ) u_pwm_div (
        .clk         (sys_clk),
        .rst_n       (rst_n_r),
        .en          (pwm_enable),                        // R4
        .tick        (base_tick),
        .divisor     (pwm_div),
        .frame_pulse (),
        .frame_tgl   (pwm_frame_freq)
    );

    // ------------------------------------------------------------
    // Shared pin mapping
    // ------------------------------------------------------------
    logic [3:0] port_mask_nxt;

    // Codes 101 to 111 fall back to all segments
    always_comb begin
        unique case (pin_map_code)
            3'b001:  port_mask_nxt = 4'b0001;             // R6
            3'b010:  port_mask_nxt = 4'b0011;             // R6
            3'b011:  port_mask_nxt = 4'b0111;             // R6
            3'b100:  port_mask_nxt = 4'b1111;             // R6
            default: port_mask_nxt = 4'b0000;             // R6
        endcase
    end

    // Registered so the pins change in one step
    always_ff @(posedge sys_clk or negedge rst_n_r) begin
        if (!rst_n_r)
            pin_port_mask <= 4'b0000;
        else
            pin_port_mask <= port_mask_nxt;
    end

    // Fourth port: plain level or pulse-width frame; static in slow mode
    always_ff @(posedge sys_clk or negedge rst_n_r) begin
        if (!rst_n_r)
            port4_out <= 1'b0;
        else if (!port_mask_nxt[3])
            port4_out <= 1'b0;
        else if (port4_func == 2'b00 || !pwm_enable)
            port4_out <= disp_data_bit10;                 // R8 R9 R10
        else
            port4_out <= pwm_frame_freq;
    end

endmodule
`default_nettype wire

/* File: lcdc_ctl_model.sv */
// Purpose : Display controller on the three-wire link
// Assumes : Bench calls send
// Notes   : Link clock idles low between frames
`timescale 1ns/10ps
`default_nettype none
module lcdc_ctl_model (
    // Clock
    input  wire logic sys_clk,
    // Shared link and separate enables
    output var logic  serial_clk_in = 1'b0,
    output var logic  serial_data_in = 1'b0,
    output var logic  chip_select_a = 1'b0,
    output var logic  chip_select_b = 1'b0
);
    // Top nb bits of w, first bit most significant; only one enable rises
    task automatic send(input logic [15:0] w, input bit dev_b, input int nb);
        int i;
        @(posedge sys_clk);
        chip_select_a <= !dev_b;
        chip_select_b <= dev_b;
        for (i = 15; i > 15 - nb; i--) begin
            @(posedge sys_clk);
            serial_data_in <= w[i];
            serial_clk_in <= 1'b0;
            @(posedge sys_clk);
            serial_clk_in <= 1'b1;
        end
        @(posedge sys_clk);
        serial_clk_in <= 1'b0;
        // Released data line must not show the last bit
        @(posedge sys_clk);
        chip_select_a <= 1'b0;
        chip_select_b <= 1'b0;
        serial_data_in <= ~serial_data_in;
        repeat (3) @(posedge sys_clk);
    endtask
endmodule
`default_nettype wire

/* File: lcdc_frame_div.sv */
// Purpose : Tick-driven frame divider producing a frame pulse and a square wave
// Assumes : tick is a one-cycle pulse from the selected base clock
// Notes   : A divisor change takes effect at the next tick (wrapping at once if the count is already past it) or on disable
`timescale 1ns/10ps
`default_nettype none
module lcdc_frame_div
    import lcdc_pkg::*;
#(
    parameter int unsigned W = DIV_W
) (
    // Clock and reset
    input  wire logic         clk,
    input  wire logic         rst_n,
    // Control
    input  wire logic         en,
    input  wire logic         tick,
    input  wire logic [W-1:0] divisor,
    // Frame outputs
    output logic              frame_pulse,
    output logic              frame_tgl
);

    logic [W-1:0] cnt_r;

    // Count base ticks; wrap at divisor-1
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_r       <= '0;
            frame_pulse <= 1'b0;
            frame_tgl   <= 1'b0;
        end else if (!en) begin
            cnt_r       <= '0;
            frame_pulse <= 1'b0;
            frame_tgl   <= 1'b0;            // Static level while disabled
        end else if (tick) begin
            if (cnt_r >= divisor - W'(1)) begin
                cnt_r       <= '0;
                frame_pulse <= 1'b1;
                frame_tgl   <= ~frame_tgl;
            end else begin
                cnt_r       <= cnt_r + W'(1);
                frame_pulse <= 1'b0;
            end
        end else begin
            frame_pulse <= 1'b0;
        end
    end

endmodule
`default_nettype wire

/* File: lcdc_pkg.sv */
// Purpose : Shared constants for the display driver clock and port configuration block
// Assumes : 250 MHz system clock, Wishbone register access, synchronous pin inputs
// Notes   : Config word layout is shared by the bus register and the serial shadow
package lcdc_pkg;

    // ------------------------------------------------------------
    // Clocking
    // ------------------------------------------------------------
    localparam int unsigned SYS_CLK_HZ   = 250_000_000;
    localparam int unsigned INT_OSC_HZ   = 300_000;           // Nominal internal oscillator rate
    localparam int unsigned INT_OSC_DIV  = SYS_CLK_HZ / INT_OSC_HZ;
    localparam int unsigned DIV_W        = 13;                // Holds 6144

    // ------------------------------------------------------------
    // Register map (byte addresses)
    // ------------------------------------------------------------
    localparam logic [3:0]  ADDR_CTRL    = 4'h0;
    localparam logic [3:0]  ADDR_STATUS  = 4'h4;
    localparam logic [3:0]  ADDR_SHADOW  = 4'h8;
    localparam logic [15:0] CTRL_RESET   = 16'h0000;

    // ------------------------------------------------------------
    // Config word fields
    // ------------------------------------------------------------
    localparam int unsigned CFG_W        = 16;
    localparam int unsigned F_CLK_SRC    = 0;
    localparam int unsigned F_EXT_RATE   = 1;
    localparam int unsigned F_PWM_LSB    = 2;                 // pwm_frame_sel_b0 is bit 2
    localparam int unsigned F_DISP_LSB   = 6;                 // disp_frame_sel_b0 is bit 6
    localparam int unsigned F_PMAP_LSB   = 10;                // {pin_map_b0,b1,b2} at 12:10
    localparam int unsigned F_P4F_LSB    = 13;
    localparam int unsigned F_D10        = 15;

    // ------------------------------------------------------------
    // Divisors
    // ------------------------------------------------------------
    localparam logic [DIV_W-1:0] PWM_DIV_BASE  = 13'd1536;
    localparam logic [DIV_W-1:0] PWM_DIV_STEP  = 13'd128;
    localparam logic [DIV_W-1:0] PWM_DIV_FIXED = 13'd896;
    localparam logic [3:0]       PWM_CODE_MAX  = 4'd10;
    localparam int unsigned      DISP_300K_MUL = 8;
    localparam logic [DIV_W-1:0] DISP_38K_DIV [16] = '{
        13'd768, 13'd672, 13'd576, 13'd480, 13'd432, 13'd384, 13'd336, 13'd288,
        13'd264, 13'd240, 13'd216, 13'd192, 13'd168, 13'd144, 13'd120, 13'd96};

    // Base clock modes
    typedef enum logic [1:0] {
        LCDC_CLK_INT,
        LCDC_CLK_EXT300,
        LCDC_CLK_EXT38
    } lcdc_clk_mode_type;

endpackage

/* File: tb_top.sv */
// Purpose : Self-checking bench for the clock and port config block
// Assumes : External clock rises every two cycles
// Notes   : Short oscillator divide keeps the run brief
`timescale 1ns/10ps
`default_nettype none
module tb_top
    import lcdc_pkg::*;
;
    localparam int         OSC = 4;
    localparam logic [3:0] PCODE [4] = '{4'd0, 4'd10, 4'd11, 4'd15};
    logic        sys_clk = 1'b0;
    logic        rstn = 1'b0;
    logic        wb_cyc_i = 1'b0;
    logic        wb_stb_i = 1'b0;
    logic        wb_we_i = 1'b0;
    logic        ext_clk_in = 1'b0;
    logic [3:0]  wb_adr_i = 4'h0;
    logic [3:0]  wb_sel_i = 4'h0;
    logic [31:0] wb_dat_i = 32'h0;
    logic [31:0] wb_dat_o, rd;
    logic [3:0]  pin_port_mask;
    logic        wb_ack_o, disp_frame_freq, pwm_frame_freq, pwm_enable, port4_out;
    wire logic   serial_clk_in, serial_data_in, chip_select_a, chip_select_b;
    int          fail_count = 0;
    int          total_checks = 0;
    int          cyc_cnt = 0;
    lcdc_clk_port_cfg #(.OSC_DIV(OSC)) i_lcdc_clk_port_cfg (.sys_clk(sys_clk), .rstn(rstn),
        .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
        .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .serial_clk_in(serial_clk_in), .serial_data_in(serial_data_in), .chip_select_a(chip_select_a),
        .ext_clk_in(ext_clk_in), .disp_frame_freq(disp_frame_freq), .pwm_frame_freq(pwm_frame_freq),
        .pwm_enable(pwm_enable), .pin_port_mask(pin_port_mask), .port4_out(port4_out));
    lcdc_ctl_model i_lcdc_ctl_model (.sys_clk(sys_clk), .serial_clk_in(serial_clk_in),
        .serial_data_in(serial_data_in), .chip_select_a(chip_select_a), .chip_select_b(chip_select_b));
    // Clocks and hang guard
    always #2 sys_clk = ~sys_clk;
    always @(posedge sys_clk) ext_clk_in <= ~ext_clk_in;
    always @(posedge sys_clk) begin
        cyc_cnt++;
        if (cyc_cnt == 95000) begin
            fail_count++;
            finish_test();
        end
    end
    // Expected values
    function automatic logic [15:0] cfg(input logic s, r, input logic [3:0] pw, dc,
                                        input logic [2:0] pm, input logic [1:0] pf, input logic d);
        return {d, pf, pm, dc, pw, r, s};
    endfunction
    function automatic logic [3:0] exp_mask(input logic [2:0] pm);
        case (pm)
            3'd1: return 4'h1;
            3'd2: return 4'h3;
            3'd3: return 4'h7;
            3'd4: return 4'hf;
            default: return 4'h0;
        endcase
    endfunction
    function automatic int exp_pwm(input logic [3:0] c);
        return (c <= 4'd10) ? 1536 - 128 * int'(c) : 896;
    endfunction
    // Compare and bus tasks
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        total_checks++;
        if (g !== e) begin
            fail_count++;
            $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic wb(input logic we, input logic [3:0] a, input logic [31:0] d, output logic [31:0] q);
        int n;
        n = 0;
        @(posedge sys_clk);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= a;
        wb_sel_i <= 4'h3;
        wb_dat_i <= d;
        do begin
            @(posedge sys_clk);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 64);
        q = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        if (n == 64) fail_count++;
    endtask
    // Configure over the link or the bus, then read back
    task automatic setc(input logic [15:0] w, input bit ser);
        if (ser) i_lcdc_ctl_model.send(w, 1'b0, 16);
        else wb(1'b1, ADDR_CTRL, {16'($urandom), w}, rd);
        repeat (3) @(posedge sys_clk);
        wb(1'b0, ADDR_CTRL, 32'h0, rd);
        chk(rd[15:0], w);
    endtask
    // Second full half period, after any pending divisor change
    task automatic half(input bit pw, output int n);
        logic v;
        repeat (3) begin
            v = pw ? pwm_frame_freq : disp_frame_freq;
            n = 0;
            do begin
                @(posedge sys_clk);
                n++;
            end while ((pw ? pwm_frame_freq : disp_frame_freq) === v && n < 20000);
        end
    endtask
    task automatic finish_test();
        if (fail_count == 0 && total_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    // Main sequence
    initial begin
        logic [15:0] w;
        logic [3:0]  c;
        logic        d;
        int          n;
        void'($urandom(78015));
        repeat (10) @(posedge sys_clk);
        rstn <= 1'b1;
        repeat (3) @(posedge sys_clk);
        wb(1'b0, ADDR_CTRL, 32'h0, rd);
        chk(rd, {16'h0, CTRL_RESET});
        chk(pwm_enable, 1'b1);
        for (int p = 0; p < 8; p++) begin
            d = 1'($urandom);
            setc(cfg(1'b1, 1'b0, 4'h0, 4'h0, 3'(p), 2'b00, d), p[0]);
            chk(pin_port_mask, exp_mask(3'(p)));
            chk(port4_out, (p == 4) ? d : 1'b0);
        end
        for (int m = 0; m < 4; m++) begin
            setc(cfg(m[0], m[1], 4'h0, 4'h0, 3'd4, 2'b01, 1'b1), 1'b0);
            wb(1'b0, ADDR_STATUS, 32'h0, rd);
            chk(rd[9:8], (m == 3) ? 2'd2 : {1'b0, m[0]});
            chk(pwm_enable, m != 3);
        end
        chk(port4_out, 1'b1);
        chk(pwm_frame_freq, 1'b0);
        for (int k = 0; k < 5; k++) begin
            c = (k < 4) ? PCODE[k] : 4'($urandom_range(9, 1));
            setc(cfg(1'b1, 1'b0, c, 4'h0, 3'd4, 2'b01, 1'b0), k[0]);
            half(1'b1, n);
            chk(n, 2 * exp_pwm(c));
            @(posedge sys_clk);
            chk(port4_out, pwm_frame_freq);
        end
        setc(cfg(1'b0, 1'b1, 4'd10, 4'h0, 3'd0, 2'b00, 1'b0), 1'b1);
        half(1'b1, n);
        chk(n, 256 * OSC);
        for (int k = 0; k < 3; k++) begin
            c = (k == 0) ? 4'd0 : (k == 1) ? 4'd15 : 4'($urandom_range(14, 1));
            setc(cfg(1'b1, 1'b1, 4'h0, c, 3'd0, 2'b00, 1'b0), k[0]);
            half(1'b0, n);
            chk(n, 2 * int'(DISP_38K_DIV[c]));
        end
        w = cfg(1'b1, 1'b1, 4'h0, 4'h3, 3'd4, 2'b00, 1'b1);
        setc(w, 1'b0);
        i_lcdc_ctl_model.send(~w, 1'b1, 16);
        wb(1'b0, ADDR_CTRL, 32'h0, rd);
        chk(rd[15:0], w);
        i_lcdc_ctl_model.send(~w, 1'b0, 10);
        wb(1'b0, ADDR_CTRL, 32'h0, rd);
        chk(rd[15:0], w);
        chk(pin_port_mask, 4'hf);
        wb(1'b1, 4'hc, $urandom, rd);
        wb(1'b0, 4'hc, 32'h0, rd);
        chk(rd, 32'h0);
        wb(1'b0, ADDR_CTRL, 32'h0, rd);
        chk(rd[15:0], w);
        finish_test();
    end
endmodule
`default_nettype wire
